// file: design/three_wire_serial_port.sv
module three_wire_serial_port (
   input  wire logic                mclk,
   input  wire logic                srst,
   input  wire csi_pkg::bus_req_t   busReq,
   output      logic [7:0]          rdData,
   input  wire logic                shiftClockPinIn,
   output      logic                shiftClockPinOut,
   output      logic                shiftClockPinOe,
   output      logic                serialOutPin,
   input  wire logic                serialInPin,
   output      logic                clockedXferDoneIrq,
   output      logic                rxValid,
   output      logic [7:0]          rxData,
   input  wire logic                rxReady,
   output      logic                txReady,
   output      logic                frameParityOdd,
   output      logic [3:0]          frameCharBits,
   output      logic [1:0]          frameStopBits,
   output      logic                frameRxSampling
);
   typedef enum logic [1:0] {
      IDLE = 2'b01,
      XFER = 2'b10
   } state_t;

   state_t     state_ff, nxt_state;
   logic [7:0] asyncFrameMode_ff;
   logic [7:0] baudSourceSel_ff;
   logic [7:0] clockedModeCtrl_ff;
   logic [7:0] transmitShift_ff;
   logic [7:0] receiveShift_ff;
   logic [7:0] receiveBuffer_ff;
   logic [3:0] bitCnt_ff;
   logic [8:0] divCnt_ff;
   logic       intSck_ff;
   logic       extSckPrev_ff;
   logic       serOutLatch_ff;
   logic       doneIrq_ff;
   logic       rxBitHold_ff;

   function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b,
                                          input logic lsbFirst);
      shiftIn = lsbFirst ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // decode
   wire        wrAfm    = busReq.wr && (busReq.addr == csi_pkg::AFM_ADDR);
   wire        wrBss    = busReq.wr && (busReq.addr == csi_pkg::BSS_ADDR);
   wire        wrCmc    = busReq.wr && (busReq.addr == csi_pkg::CMC_ADDR);
   wire        wrTxs    = busReq.wr && (busReq.addr == csi_pkg::TXS_ADDR);
   wire        csiEn    = clockedModeCtrl_ff[csi_pkg::CSIE_BIT];
   wire        lsbFirst = clockedModeCtrl_ff[csi_pkg::DIR_BIT];
   wire        intClk   = clockedModeCtrl_ff[csi_pkg::CSCK_BIT];
   wire [3:0]  srcSel   = baudSourceSel_ff[3:0];
   // n = srcSel+1; half period of shift clock = 2^n system clocks
   wire [8:0]  halfPer  = 9'h001 << (srcSel + 4'h1);
   wire        divWrap  = (divCnt_ff == halfPer - 9'h001);
   // selector only matters for internal clock
   wire        intFall  = intClk && (state_ff == XFER) && divWrap && intSck_ff;
   wire        intRise  = intClk && (state_ff == XFER) && divWrap && !intSck_ff;
   wire        extFall  = !intClk && extSckPrev_ff && !shiftClockPinIn;
   wire        extRise  = !intClk && !extSckPrev_ff && shiftClockPinIn;
   wire        sckFall  = (state_ff == XFER) && (intFall || extFall);
   wire        sckRise  = (state_ff == XFER) && (intRise || extRise);
   wire        sckIdleHi = intClk ? 1'b1 : shiftClockPinIn;
   // enable must already be set when data is written
   wire        startXfer = wrTxs && csiEn && (state_ff == IDLE) && sckIdleHi;
   wire        lastBit   = sckRise && (bitCnt_ff == csi_pkg::XFER_BITS - 4'h1);
   wire        fifoInReady;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         IDLE: if (startXfer) nxt_state = XFER;
         XFER: if (lastBit) nxt_state = IDLE;
         default: nxt_state = IDLE;
      endcase
   end

   // prohibited codes are not stored
   wire        bssOk    = (busReq.wdata[3:0] <= csi_pkg::BSS_MAX);

   always_ff @(posedge mclk) begin
      if (srst) begin
         asyncFrameMode_ff <= csi_pkg::AFM_RST;
      end else if (wrAfm) begin
         asyncFrameMode_ff <= busReq.wdata & csi_pkg::AFM_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         baudSourceSel_ff <= csi_pkg::BSS_RST;
      end else if (wrBss && bssOk) begin
         baudSourceSel_ff <= busReq.wdata & csi_pkg::BSS_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         clockedModeCtrl_ff <= csi_pkg::CMC_RST;
      end else if (wrCmc) begin
         clockedModeCtrl_ff <= busReq.wdata & csi_pkg::CMC_MASK;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_ff      <= IDLE;
         divCnt_ff     <= '0;
         intSck_ff     <= 1'b1;
         extSckPrev_ff <= 1'b1;
      end else begin
         state_ff      <= nxt_state;
         extSckPrev_ff <= shiftClockPinIn;
         if (state_ff != XFER || divWrap) divCnt_ff <= '0;
         else divCnt_ff <= divCnt_ff + 9'h001;
         if (state_ff != XFER) intSck_ff <= 1'b1;
         else if (divWrap && intClk) intSck_ff <= !intSck_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         transmitShift_ff <= '0;
         receiveShift_ff  <= '0;
         receiveBuffer_ff <= '0;
         bitCnt_ff        <= '0;
         serOutLatch_ff   <= 1'b1;
         rxBitHold_ff     <= 1'b0;
         doneIrq_ff       <= 1'b0;
      end else begin
         doneIrq_ff <= lastBit;
         if (startXfer) begin
            transmitShift_ff <= busReq.wdata;
            bitCnt_ff        <= '0;
            serOutLatch_ff   <= lsbFirst ? busReq.wdata[0] : busReq.wdata[7];
         end else if (sckFall && bitCnt_ff != '0) begin
            // advance shifters, next bit into output latch
            transmitShift_ff <= lsbFirst ? {1'b0, transmitShift_ff[7:1]}
                                         : {transmitShift_ff[6:0], 1'b0};
            serOutLatch_ff   <= lsbFirst ? transmitShift_ff[1] : transmitShift_ff[6];
            receiveShift_ff  <= shiftIn(receiveShift_ff, rxBitHold_ff, lsbFirst);
         end
         if (sckRise) begin
            rxBitHold_ff <= serialInPin;
            bitCnt_ff    <= bitCnt_ff + 4'h1;
         end
         if (lastBit) receiveBuffer_ff <= shiftIn(receiveShift_ff, serialInPin, lsbFirst);
      end
   end

   // completed receive words also queue into the stream FIFO when not full; a word completing on a full FIFO is dropped
   sync_fifo #(.WIDTH(csi_pkg::DATA_W), .DEPTH(csi_pkg::FIFO_DEPTH)) rxFifo (
      .mclk     (mclk),
      .srst     (srst),
      .inData   (receiveBuffer_ff),
      .inValid  (doneIrq_ff),
      .inReady  (fifoInReady),
      .outData  (rxData),
      .outValid (rxValid),
      .outReady (rxReady)
   );
   // txReady only while queue has room, enabled and idle; startXfer ignores queue room
   assign txReady = fifoInReady && csiEn && (state_ff == IDLE);

   // read selection
   wire        rdAfm    = (busReq.addr == csi_pkg::AFM_ADDR);
   wire        rdBss    = (busReq.addr == csi_pkg::BSS_ADDR);
   wire        rdCmc    = (busReq.addr == csi_pkg::CMC_ADDR);
   wire        rdTxs    = (busReq.addr == csi_pkg::TXS_ADDR);
   wire        rdRxb    = (busReq.addr == csi_pkg::RXB_ADDR);
   assign rdData = rdAfm ? asyncFrameMode_ff :
                   rdBss ? baudSourceSel_ff :
                   rdCmc ? clockedModeCtrl_ff :
                   rdTxs ? transmitShift_ff :
                   rdRxb ? receiveBuffer_ff : 8'h00;

   assign shiftClockPinOut   = intSck_ff;
   assign shiftClockPinOe    = intClk && csiEn;
   assign serialOutPin       = serOutLatch_ff;
   assign clockedXferDoneIrq = doneIrq_ff;
   // frame mode decode for the asynchronous path
   assign frameParityOdd  = asyncFrameMode_ff[csi_pkg::PARH_BIT] &&
                            !asyncFrameMode_ff[csi_pkg::PARL_BIT];
   assign frameCharBits   = asyncFrameMode_ff[csi_pkg::CL_BIT] ? 4'h8 : 4'h7;
   assign frameStopBits   = asyncFrameMode_ff[csi_pkg::SL_BIT] ? 2'h2 : 2'h1;
   assign frameRxSampling = asyncFrameMode_ff[csi_pkg::RXE_BIT];

   // edge and cycle counters for checks that span many clocks
   logic [3:0] riseSeen_ff;
   logic [3:0] fallSeen_ff;
   logic [8:0] lowRun_ff;
   logic [8:0] highRun_ff;

   always_ff @(posedge mclk) begin
      if (srst || startXfer) begin
         riseSeen_ff <= '0;
         fallSeen_ff <= '0;
      end else begin
         if (sckRise) riseSeen_ff <= riseSeen_ff + 4'h1;
         if (sckFall) fallSeen_ff <= fallSeen_ff + 4'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || intSck_ff) begin
         lowRun_ff <= '0;
      end else begin
         lowRun_ff <= lowRun_ff + 9'h001;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || !intSck_ff || state_ff != XFER) begin
         highRun_ff <= '0;
      end else begin
         highRun_ff <= highRun_ff + 9'h001;
      end
   end

   sequence eighth_rise_s;
      sckRise && riseSeen_ff == 4'h7;
   endsequence
   sequence done_stop_s;
      clockedXferDoneIrq && state_ff == IDLE ##1 !clockedXferDoneIrq;
   endsequence

   reset_regs_a: assert property (@(posedge mclk) srst |=>
      asyncFrameMode_ff == 8'h00 && baudSourceSel_ff == 8'h00)
      else $error("registers not cleared by reset");
   no_late_start_a: assert property (@(posedge mclk) disable iff (srst)
      (wrTxs && !csiEn && state_ff == IDLE) |=> state_ff == IDLE)
      else $error("transfer started while disabled");
   done_pulse_a: assert property (@(posedge mclk) disable iff (srst)
      lastBit |=> clockedXferDoneIrq && state_ff == IDLE)
      else $error("completion not flagged");
   eight_bits_a: assert property (@(posedge mclk) disable iff (srst)
      clockedXferDoneIrq |-> riseSeen_ff == 4'h8)
      else $error("transfer not eight bits");
   ext_no_div_a: assert property (@(posedge mclk) disable iff (srst)
      !intClk |-> !shiftClockPinOe && shiftClockPinOut)
      else $error("driving clock in external mode");
   idle_clock_a: assert property (@(posedge mclk) disable iff (srst)
      state_ff == IDLE |=> shiftClockPinOut)
      else $error("internal clock not idle high");
   out_stable_a: assert property (@(posedge mclk) disable iff (srst)
      (state_ff == XFER && !sckFall && !startXfer) |=> $stable(serialOutPin))
      else $error("output changed off a falling edge");
   start_cond_a: assert property (@(posedge mclk) disable iff (srst)
      (state_ff == IDLE && $past(state_ff) == IDLE && state_ff != nxt_state)
      |-> wrTxs && csiEn)
      else $error("illegal start");
   stop_after_eight_a: assert property (@(posedge mclk) disable iff (srst)
      eighth_rise_s |=> done_stop_s)
      else $error("transfer did not stop after eight bits");
   eight_falls_a: assert property (@(posedge mclk) disable iff (srst)
      clockedXferDoneIrq |-> fallSeen_ff == 4'h8)
      else $error("transfer not eight falling edges");
   baud_reject_a: assert property (@(posedge mclk) disable iff (srst)
      (wrBss && !bssOk) |=> $stable(baudSourceSel_ff))
      else $error("prohibited baud code stored");
   half_low_a: assert property (@(posedge mclk) disable iff (srst)
      intRise |-> lowRun_ff == halfPer - 9'h001)
      else $error("low half period wrong");
   half_high_a: assert property (@(posedge mclk) disable iff (srst)
      intFall |-> highRun_ff == halfPer - 9'h001)
      else $error("high half period wrong");
   rise_sample_a: assert property (@(posedge mclk) disable iff (srst)
      sckRise |=> rxBitHold_ff == $past(serialInPin))
      else $error("input not taken on rising edge");
   first_bit_a: assert property (@(posedge mclk) disable iff (srst)
      startXfer |=> serialOutPin ==
                    (lsbFirst ? $past(busReq.wdata[0]) : $past(busReq.wdata[7])))
      else $error("first bit not in output latch");
   ctrl_reset_a: assert property (@(posedge mclk) srst |=>
      clockedModeCtrl_ff == 8'h00)
      else $error("control register not cleared by reset");
   queue_push_a: assert property (@(posedge mclk) disable iff (srst)
      clockedXferDoneIrq |=> rxValid)
      else $error("received byte not queued");
endmodule // three_wire_serial_port

// file: design/csi_pkg.sv
package csi_pkg;
   // register addresses (16-bit memory-mapped space)
   localparam logic [15:0] AFM_ADDR  = 16'hFF70;
   localparam logic [15:0] CMC_ADDR  = 16'hFF72;
   localparam logic [15:0] TXS_ADDR  = 16'hFF71;
   localparam logic [15:0] BSS_ADDR  = 16'hFF73;
   localparam logic [15:0] RXB_ADDR  = 16'hFF74;
   // reset values
   localparam logic [7:0]  AFM_RST   = 8'h00;
   localparam logic [7:0]  BSS_RST   = 8'h00;
   localparam logic [7:0]  CMC_RST   = 8'h00;
   // field positions
   localparam int TXE_BIT  = 7;
   localparam int RXE_BIT  = 6;
   localparam int PARH_BIT = 5;
   localparam int PARL_BIT = 4;
   localparam int CL_BIT   = 3;
   localparam int SL_BIT   = 2;
   localparam int CSIE_BIT = 7;
   localparam int DIR_BIT  = 2;
   localparam int CSCK_BIT = 1;
   localparam logic [7:0] AFM_MASK = 8'hFC;
   localparam logic [7:0] CMC_MASK = 8'h86;
   localparam logic [7:0] BSS_MASK = 8'h0F;
   localparam logic [3:0] BSS_MAX  = 4'h7;
   localparam logic [3:0] XFER_BITS = 4'h8;
   localparam int FIFO_DEPTH = 32;
   localparam int DATA_W     = 8;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic sckOut;
      logic sckOe;
      logic serOut;
   } pin_out_t;
endpackage : csi_pkg

// file: design/sync_fifo.sv
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output      logic             inReady,
   output      logic [WIDTH-1:0] outData,
   output      logic             outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_ff;
   logic [AW-1:0]    rdPtr_ff;
   logic [AW:0]      count_ff;
   wire              push = inValid && inReady;
   wire              pop  = outValid && outReady;

   assign inReady  = (count_ff != (AW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem[rdPtr_ff];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
         if (pop)  rdPtr_ff <= rdPtr_ff + 1'b1;
         count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // sync_fifo

// file: bench/sync_serial_peer.sv
module sync_serial_peer (
   input  wire logic sck,
   input  wire logic serOut,
   input  wire logic lsbFirst,
   output      logic serIn,
   output      logic sckDrive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] txByte;
   logic [7:0] rxByte;
   int         bitCnt;
   initial begin
      serIn    = 1'b1;
      sckDrive = 1'b1;
      txByte   = 8'h00;
      rxByte   = 8'h00;
      bitCnt   = 8;
   end
   function automatic logic pick(input int i);
      return lsbFirst ? txByte[i] : txByte[7-i];
   endfunction
   task automatic load(input logic [7:0] b);
      txByte = b;
      bitCnt = 0;
      serIn  = pick(0);
   endtask
   // sample on rise; line released (inverted) after the last bit
   always @(posedge sck) begin
      if (bitCnt < 8) begin
         rxByte = lsbFirst ? {serOut, rxByte[7:1]} : {rxByte[6:0], serOut};
         bitCnt++;
         if (bitCnt == 8) serIn <= #50 ~serIn;
      end
   end
   // next bit goes out on fall
   always @(negedge sck) begin
      if (bitCnt > 0 && bitCnt < 8) serIn = pick(bitCnt);
   end
   // external clock stands high between frames
   task automatic clockOut(input int halfNs);
      repeat (8) begin
         #halfNs sckDrive = 1'b0;
         #halfNs sckDrive = 1'b1;
      end
   endtask
endmodule // sync_serial_peer

// file: bench/three_wire_serial_port_tb_top.sv
module three_wire_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk    = 1'b0;
   logic              srst    = 1'b1;
   csi_pkg::bus_req_t busReq  = '0;
   logic              rxReady = 1'b0;
   logic              peerLsb = 1'b0;
   logic [7:0]        rdData, rxData;
   logic              sckOut, sckOe, serOut, serIn, sckDrive, irq, rxValid, txReady;
   logic              parOdd, rxSamp;
   logic [3:0]        charBits;
   logic [1:0]        stopBits;
   wire               sck;
   int                miscompares    = 0;
   int                samplesChecked = 0;
   always #5 mclk = ~mclk;
   assign sck = sckOe ? sckOut : sckDrive;
   three_wire_serial_port dut (.mclk(mclk), .srst(srst), .busReq(busReq), .rdData(rdData),
      .shiftClockPinIn(sck), .shiftClockPinOut(sckOut), .shiftClockPinOe(sckOe),
      .serialOutPin(serOut), .serialInPin(serIn), .clockedXferDoneIrq(irq),
      .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .txReady(txReady),
      .frameParityOdd(parOdd), .frameCharBits(charBits), .frameStopBits(stopBits),
      .frameRxSampling(rxSamp));
   sync_serial_peer peer (.sck(sck), .serOut(serOut), .lsbFirst(peerLsb), .serIn(serIn),
      .sckDrive(sckDrive));
   task automatic results();
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      busReq.wr    = 1'b1;
      busReq.addr  = a;
      busReq.wdata = d;
      @(negedge mclk);
      busReq.wr = 1'b0;
   endtask
   task automatic rdChk(input string name, input logic [15:0] a, input logic [7:0] exp);
      @(negedge mclk);
      busReq.addr = a;
      #1 check(name, rdData, exp);
   endtask
   task automatic waitIrq(input int lim, output bit seen, output int lowCnt);
      seen   = 1'b0;
      lowCnt = 0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(negedge mclk);
         if (sckOut === 1'b0) lowCnt++;
         if (irq === 1'b1) seen = 1'b1;
      end
   endtask
   task automatic resetValues();
      rdChk("frame", csi_pkg::AFM_ADDR, 8'h00);
      rdChk("ctrl", csi_pkg::CMC_ADDR, 8'h00);
      rdChk("baud", csi_pkg::BSS_ADDR, 8'h00);
      check("sckIdle", 8'(sckOut), 8'h01);
   endtask
   task automatic midReset();
      @(negedge mclk);
      srst = 1'b1;
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      resetValues();
   endtask
   task automatic frameDecode();
      wr(csi_pkg::AFM_ADDR, 8'hFC);
      rdChk("frameMask", csi_pkg::AFM_ADDR, 8'hFC);
      for (int p = 0; p < 4; p++) begin
         wr(csi_pkg::AFM_ADDR, {2'b01, p[1:0], 4'hC});
         rdChk("frame", csi_pkg::AFM_ADDR, {2'b01, p[1:0], 4'hC});
         check("parityOdd", 8'(parOdd), 8'(p == 2));
         check("charBits", 8'(charBits), 8'h08);
         check("stopBits", 8'(stopBits), 8'h02);
         check("rxSampling", 8'(rxSamp), 8'h01);
      end
      wr(csi_pkg::AFM_ADDR, 8'h00);
      check("charBits", 8'(charBits), 8'h07);
      check("stopBits", 8'(stopBits), 8'h01);
      check("rxSampling", 8'(rxSamp), 8'h00);
   endtask
   task automatic baudSelect();
      wr(csi_pkg::BSS_ADDR, 8'h09);
      rdChk("baudBad", csi_pkg::BSS_ADDR, 8'h00);
      wr(csi_pkg::BSS_ADDR, 8'hF7);
      rdChk("baudTop", csi_pkg::BSS_ADDR, 8'h07);
      wr(csi_pkg::BSS_ADDR, 8'h01);
      rdChk("baud", csi_pkg::BSS_ADDR, 8'h01);
   endtask
   task automatic lateEnable();
      bit seen;
      int low;
      check("txReadyOff", 8'(txReady), 8'h00);
      wr(csi_pkg::TXS_ADDR, 8'h55);
      wr(csi_pkg::CMC_ADDR, 8'h82);
      waitIrq(200, seen, low);
      check("lateIrq", 8'(seen), 8'h00);
      check("lateSck", 8'(low), 8'h00);
   endtask
   task automatic xfer(input logic [7:0] ctrl, tx, rx, input bit ext, input int expLow);
      bit seen;
      int low;
      wr(csi_pkg::CMC_ADDR, ctrl);
      peerLsb = ctrl[2];
      peer.load(rx);
      check("txReadyIdle", 8'(txReady), 8'h01);
      wr(csi_pkg::TXS_ADDR, tx);
      check("txReadyBusy", 8'(txReady), 8'h00);
      if (ext) fork
         peer.clockOut(200);
      join_none
      waitIrq(2000, seen, low);
      check("irq", 8'(seen), 8'h01);
      check("sckLow", 8'(low), 8'(expLow));
      check("peerRx", peer.rxByte, tx);
      rdChk("rxBuf", csi_pkg::RXB_ADDR, rx);
      for (int i = 0; i < 10 && rxValid !== 1'b1; i++) @(negedge mclk);
      check("rxData", rxData, rx);
      rxReady = 1'b1;
      @(negedge mclk);
      rxReady = 1'b0;
   endtask
   initial begin
      repeat (12) @(negedge mclk);
      srst = 1'b0;
      resetValues();
      frameDecode();
      baudSelect();
      lateEnable();
      // msb first, internal clock, code 1: eight low halves of 4 cycles
      xfer(8'h82, 8'hA5, 8'h3C, 1'b0, 32);
      wr(csi_pkg::BSS_ADDR, 8'h07);
      xfer(8'h84, 8'h96, 8'hE1, 1'b1, 0);
      midReset();
      results();
   end
   initial begin
      #100000;
      miscompares++;
      results();
   end
endmodule // three_wire_serial_port_tb_top
